// [rtl/acmpc_top.sv]
// Mode control, sample path, event pins and register file of the accelerometer core.
// Assumes an AXI4-Lite master on the core clock and raw samples on the core clock.
`timescale 1ns/1ns
`default_nettype none
module acmpc_top
    import acmpc_pkg::*;
#(
    parameter int BASE_DIV_P = BASE_DIV,
    parameter int WAKE_DIV_P = WAKE_DIV,
    parameter int EXT_DIV_P = EXT_DIV
)
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // AXI4-Lite write
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // Serial port
    input wire logic SCLK_I,
    input wire logic MOSI_I,
    input wire logic CS_N_I,
    output logic MISO_O,
    output logic MISO_OE_N_O,
    // Sensor
    input wire logic [RAW_W-1:0] ACCEL_RAW_I,
    // Event pins
    input wire logic EVENT_PIN_A_CLOCK_IN_I,
    output logic EVENT_PIN_A_CLOCK_IN_O,
    output logic EVENT_PIN_A_CLOCK_IN_OE_N_O,
    input wire logic EVENT_PIN_B_SYNC_IN_I,
    output logic EVENT_PIN_B_SYNC_IN_O,
    output logic EVENT_PIN_B_SYNC_IN_OE_N_O,
    output logic AWAKE_O
);
    if (BASE_DIV_P < 2 || BASE_DIV_P > 2 ** 26 || WAKE_DIV_P < 2 || EXT_DIV_P < 1)
        $error("acmpc_top: divider parameter out of range");

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] thr;
        logic drdy;
        logic mot;
        logic awake;
        logic [SMP_W-1:0] data;
        logic [1:0] settle;
        logic [7:0] act;
        logic restart;
        logic [2:0] pa;
        logic [2:0] pb;
        logic awrdy;
        logic wrdy;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pa_o;
        logic pa_oe_n;
        logic pb_o;
        logic pb_oe_n;
    } acmpc_st_s;

    acmpc_st_s s_q;
    acmpc_st_s s_d;
    acmpc_spi_if spi_bus ();
    logic tick;
    logic wr_go;
    logic [7:0] wr_a;
    logic [31:0] wr_d;
    logic [3:0] wr_s;
    logic rd_hit;
    logic evt;
    logic over;
    logic [SMP_W-1:0] scaled;
    logic [SMP_W:0] mag;
    logic [31:0] spi_word;
    acmpc_mode_e mode;

    function automatic logic mapped(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_STAT || a == OFS_DATA || a == OFS_THR;
    endfunction

    function automatic logic [31:0] reg_read(input acmpc_st_s s, input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        case (a)
            OFS_CTRL: r = s.ctrl;
            OFS_STAT:
            begin
                r[S_DRDY] = s.drdy;
                r[S_MOT] = s.mot;
                r[S_AWAKE] = s.awake;
            end
            OFS_DATA: r = {{(32 - SMP_W){s.data[SMP_W-1]}}, s.data};
            OFS_THR: r = s.thr;
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] st, input logic [31:0] m);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (st[i])
                r[8*i +: 8] = d[8*i +: 8];
        return r & m;
    endfunction

    function automatic logic [SMP_W-1:0] clip(input logic [RAW_W-1:0] v, input logic [1:0] rg);
        logic signed [RAW_W-1:0] x;
        x = $signed(v) >>> ((rg > 2'h2) ? 2'h2 : rg);
        if (x > $signed(16'h07FF))
            return 12'h7FF;
        else if (x < $signed(16'hF800))
            return 12'h800;
        else
            return x[SMP_W-1:0];
    endfunction

    assign spi_word = reg_read(s_q, {1'b0, spi_bus.addr[6:2], 2'b00});
    assign spi_bus.rdata = 8'(spi_word >> {spi_bus.addr[1:0], 3'b000});
    assign mode = acmpc_mode_e'(s_q.ctrl[C_MODE +: 2]);

    always_comb
    begin
        s_d = s_q;
        s_d.restart = 1'b0;
        wr_go = 1'b0;
        wr_a = '0;
        wr_d = '0;
        wr_s = '0;
        rd_hit = 1'b0;
        // Write channels, either order
        if (S_AXI_AWVALID_I && s_q.awrdy)
        begin
            s_d.awrdy = 1'b0;
            s_d.awa = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && s_q.wrdy)
        begin
            s_d.wrdy = 1'b0;
            s_d.wd = S_AXI_WDATA_I;
            s_d.ws = S_AXI_WSTRB_I;
        end
        if (!s_q.awrdy && !s_q.wrdy && !s_q.bvalid)
        begin
            s_d.bvalid = 1'b1;
            s_d.bresp = mapped(s_q.awa) ? RESP_OKAY : RESP_SLVERR;
            wr_go = 1'b1;
            wr_a = s_q.awa;
            wr_d = s_q.wd;
            wr_s = s_q.ws;
        end
        else if (spi_bus.wr)
        begin
            wr_go = 1'b1;
            wr_a = {1'b0, spi_bus.addr[6:2], 2'b00};
            wr_d = {4{spi_bus.wdata}};
            wr_s = 4'h1 << spi_bus.addr[1:0];
        end
        if (s_q.bvalid && S_AXI_BREADY_I)
        begin
            s_d.bvalid = 1'b0;
            s_d.awrdy = 1'b1;
            s_d.wrdy = 1'b1;
        end
        // Read channel
        if (S_AXI_ARVALID_I && s_q.arrdy)
        begin
            s_d.arrdy = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rdata = reg_read(s_q, S_AXI_ARADDR_I);
            s_d.rresp = mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
            rd_hit = S_AXI_ARADDR_I == OFS_DATA;
        end
        if (s_q.rvalid && S_AXI_RREADY_I)
        begin
            s_d.rvalid = 1'b0;
            s_d.arrdy = 1'b1;
        end
        if (spi_bus.rd && {1'b0, spi_bus.addr[6:2], 2'b00} == OFS_DATA)
            rd_hit = 1'b1;
        // Register writes and clears
        if (wr_go && wr_a == OFS_CTRL)
            s_d.ctrl = merge(s_q.ctrl, wr_d, wr_s, CTRL_MASK);
        if (wr_go && wr_a == OFS_THR)
            s_d.thr = merge(s_q.thr, wr_d, wr_s, THR_MASK);
        if (wr_go && wr_a == OFS_STAT && wr_s[0])
        begin
            s_d.drdy = s_q.drdy & ~wr_d[S_DRDY];
            s_d.mot = s_q.mot & ~wr_d[S_MOT];
            s_d.awake = s_q.awake & ~wr_d[S_AWAKE];
        end
        if (rd_hit)
            s_d.drdy = 1'b0;
        // Pin synchronisers
        s_d.pa = {s_q.pa[1:0], EVENT_PIN_A_CLOCK_IN_I};
        s_d.pb = {s_q.pb[1:0], EVENT_PIN_B_SYNC_IN_I};
        // Sample path, events win over clears
        evt = 1'b0;
        if (mode == ACMPC_MEAS)
            evt = s_q.ctrl[C_PINB] ? (s_q.pb[1] & ~s_q.pb[2]) : tick;
        else if (mode == ACMPC_WAKE)
            evt = tick;
        scaled = clip(ACCEL_RAW_I, s_q.ctrl[C_RANGE +: 2]);
        mag = scaled[SMP_W-1] ? 13'(-$signed(scaled)) : {1'b0, scaled};
        over = mag > {2'b00, s_q.thr[T_LVL +: 11]};
        if (evt)
        begin
            if (s_q.settle != 2'h0)
                s_d.settle = s_q.settle - 2'h1;
            else
            begin
                s_d.data = scaled;
                s_d.drdy = 1'b1;
            end
            if (!over)
                s_d.act = '0;
            else if (mode == ACMPC_WAKE || s_q.act + 8'h1 >= s_q.thr[T_TIME +: 8])
            begin
                s_d.act = '0;
                s_d.mot = 1'b1;
                s_d.awake = 1'b1;
                if (mode == ACMPC_WAKE && s_q.ctrl[C_AUTO])
                    s_d.ctrl[C_MODE +: 2] = ACMPC_MEAS;
            end
            else
                s_d.act = s_q.act + 8'h1;
        end
        if (s_d.ctrl[C_MODE +: 2] == ACMPC_MEAS && mode != ACMPC_MEAS)
        begin
            s_d.settle = SETTLE_N;
            s_d.restart = 1'b1;
            s_d.act = '0;
        end
        // Event pins released when used as inputs
        s_d.pa_oe_n = s_d.ctrl[C_PINA];
        s_d.pb_oe_n = s_d.ctrl[C_PINB];
        s_d.pa_o = s_d.ctrl[C_INTEN] & s_d.mot & ~s_d.ctrl[C_PINA];
        s_d.pb_o = s_d.ctrl[C_INTEN] & s_d.drdy & ~s_d.ctrl[C_PINB];
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESETN_I)
            s_q <= '{ctrl: CTRL_RST, thr: THR_RST, awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1,
                     pa_oe_n: 1'b0, pb_oe_n: 1'b0, default: '0};
        else
            s_q <= s_d;
    end

    acmpc_timebase #(
        .BASE_DIV_P(BASE_DIV_P),
        .WAKE_DIV_P(WAKE_DIV_P),
        .EXT_DIV_P(EXT_DIV_P)
    ) u_timebase (
        .clk_i(CLK_I),
        .rst_n_i(RESETN_I),
        .run_i(mode == ACMPC_MEAS || mode == ACMPC_WAKE),
        .wake_i(mode == ACMPC_WAKE),
        .restart_i(s_q.restart),
        .odr_i(s_q.ctrl[C_ODR +: 3]),
        .ext_en_i(s_q.ctrl[C_PINA]),
        .ext_step_i(s_q.pa[1] & ~s_q.pa[2]),
        .tick_o(tick)
    );

    acmpc_spi u_spi (
        .clk_i(CLK_I),
        .rst_n_i(RESETN_I),
        .sclk_i(SCLK_I),
        .mosi_i(MOSI_I),
        .cs_n_i(CS_N_I),
        .miso_o(MISO_O),
        .miso_oe_n_o(MISO_OE_N_O),
        .bus(spi_bus.port)
    );

    assign S_AXI_AWREADY_O = s_q.awrdy;
    assign S_AXI_WREADY_O = s_q.wrdy;
    assign S_AXI_BRESP_O = s_q.bresp;
    assign S_AXI_BVALID_O = s_q.bvalid;
    assign S_AXI_ARREADY_O = s_q.arrdy;
    assign S_AXI_RDATA_O = s_q.rdata;
    assign S_AXI_RRESP_O = s_q.rresp;
    assign S_AXI_RVALID_O = s_q.rvalid;
    assign EVENT_PIN_A_CLOCK_IN_O = s_q.pa_o;
    assign EVENT_PIN_A_CLOCK_IN_OE_N_O = s_q.pa_oe_n;
    assign EVENT_PIN_B_SYNC_IN_O = s_q.pb_o;
    assign EVENT_PIN_B_SYNC_IN_OE_N_O = s_q.pb_oe_n;
    assign AWAKE_O = s_q.awake;

    // Wait counter from measurement entry to first delivered sample
    logic wait_q;
    logic [31:0] wcnt_q;
    always_ff @(posedge CLK_I)
    begin
        if (!RESETN_I)
        begin
            wait_q <= 1'b0;
            wcnt_q <= '0;
        end
        else if (s_q.restart)
        begin
            wait_q <= 1'b1;
            wcnt_q <= '0;
        end
        else if (wait_q)
        begin
            wait_q <= !(s_d.drdy && !s_q.drdy) && mode == ACMPC_MEAS;
            wcnt_q <= wcnt_q + 32'h1;
        end
    end

    a_first_sample: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        wait_q && !s_q.ctrl[C_PINA] && !s_q.ctrl[C_PINB] |->
        wcnt_q <= acmpc_period(s_q.ctrl[C_ODR +: 3], 32'(BASE_DIV_P)) << 2)
        else $error("first sample later than four periods");
    a_stby_no_event: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        mode == ACMPC_STBY |=> !$rose(s_q.mot) && !$rose(s_q.drdy))
        else $error("event raised in standby");
    a_reset_standby: assert property (@(posedge CLK_I)
        $rose(RESETN_I) |-> mode == ACMPC_STBY && !s_q.mot && !s_q.drdy)
        else $error("not in standby after reset");
    a_pin_a_release: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_q.ctrl[C_PINA] |-> EVENT_PIN_A_CLOCK_IN_OE_N_O)
        else $error("pin A driven while an input");
    a_pin_b_release: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_q.ctrl[C_PINB] ##1 s_q.ctrl[C_PINB] |-> EVENT_PIN_B_SYNC_IN_OE_N_O)
        else $error("pin B driven while an input");
    a_data_clip: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        evt && s_q.settle == 2'h0 |=> s_q.data == $past(scaled) && s_q.drdy)
        else $error("sample not stored");
    a_wake_single: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        evt && mode == ACMPC_WAKE && over |=> s_q.mot ##1 AWAKE_O)
        else $error("wake motion not flagged");
    a_wake_auto: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        evt && mode == ACMPC_WAKE && over && s_q.ctrl[C_AUTO] |=>
        mode == ACMPC_MEAS && s_q.restart)
        else $error("no switch to measurement");
    c_wake_to_meas: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
        mode == ACMPC_WAKE ##1 mode == ACMPC_MEAS);
    c_axi_data_read: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
        S_AXI_ARVALID_I && s_q.arrdy && S_AXI_ARADDR_I == OFS_DATA && s_q.drdy);
endmodule
`default_nettype wire

// [common/acmpc_pkg.sv]
// Shared constants, types and helpers for the acceleration mode and pin control block.
// Assumes a 125 MHz core clock and a 32-bit register bus.
package acmpc_pkg;
    // Time base
    localparam int CLK_HZ = 125_000_000;
    localparam int ODR_MAX_HZ = 400;
    localparam int WAKE_HZ = 6;
    localparam int BASE_DIV = CLK_HZ / ODR_MAX_HZ;
    localparam int WAKE_DIV = CLK_HZ / WAKE_HZ;
    localparam int EXT_DIV = 128;
    // Rate select 0..5 gives 12.5 Hz up to 400 Hz
    localparam logic [2:0] ODR_SEL_MAX = 3'h5;
    localparam logic [1:0] SETTLE_N = 2'h2;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_THR = 8'h0C;
    // Control fields
    localparam int C_MODE = 0;
    localparam int C_RANGE = 2;
    localparam int C_ODR = 4;
    localparam int C_AUTO = 7;
    localparam int C_PINA = 8;
    localparam int C_PINB = 9;
    localparam int C_INTEN = 10;
    localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;
    localparam logic [31:0] CTRL_RST = 32'h0000_0030;
    // Status fields
    localparam int S_DRDY = 0;
    localparam int S_MOT = 1;
    localparam int S_AWAKE = 2;
    // Threshold fields
    localparam int T_LVL = 0;
    localparam int T_TIME = 16;
    localparam logic [31:0] THR_MASK = 32'h00FF_07FF;
    localparam logic [31:0] THR_RST = 32'h0001_0100;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Serial frame
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] FRAME_LAST = 5'h0F;
    // Sample widths
    localparam int RAW_W = 16;
    localparam int SMP_W = 12;

    typedef enum logic [1:0] {
        ACMPC_STBY = 2'h0,
        ACMPC_MEAS = 2'h2,
        ACMPC_WAKE = 2'h3
    } acmpc_mode_e;

    function automatic logic [31:0] acmpc_period(input logic [2:0] odr, input logic [31:0] base);
        logic [2:0] sel;
        sel = (odr > ODR_SEL_MAX) ? ODR_SEL_MAX : odr;
        return base << (ODR_SEL_MAX - sel);
    endfunction
endpackage

// [common/acmpc_spi_if.sv]
// Register access path from the serial port into the register file.
// Assumes both ends run on the core clock.
`timescale 1ns/1ns
`default_nettype none
interface acmpc_spi_if;
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output wr, output rd, output addr, output wdata, input rdata);
    modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [rtl/acmpc_timebase.sv]
// Sample tick generator for measurement, wake-up and external clock timing.
// Assumes run, rate and step inputs come from the core clock domain.
`timescale 1ns/1ns
`default_nettype none
module acmpc_timebase
    import acmpc_pkg::*;
#(
    parameter int BASE_DIV_P = BASE_DIV,
    parameter int WAKE_DIV_P = WAKE_DIV,
    parameter int EXT_DIV_P = EXT_DIV
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic run_i,
    input wire logic wake_i,
    input wire logic restart_i,
    input wire logic [2:0] odr_i,
    input wire logic ext_en_i,
    input wire logic ext_step_i,
    // Tick
    output logic tick_o
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } acmpc_tb_s;

    acmpc_tb_s s_q;
    acmpc_tb_s s_d;
    logic [31:0] per;
    logic step;

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        step = (ext_en_i && !wake_i) ? ext_step_i : 1'b1;
        if (wake_i)
            per = 32'(WAKE_DIV_P);
        else if (ext_en_i)
            per = acmpc_period(odr_i, 32'(EXT_DIV_P));
        else
            per = acmpc_period(odr_i, 32'(BASE_DIV_P));
        if (!run_i || restart_i)
            s_d.cnt = '0;
        else if (step)
        begin
            if (s_q.cnt >= per - 32'h1)
            begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end
            else
                s_d.cnt = s_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tick_o = s_q.tick;

    a_tick_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !run_i |=> !tick_o)
        else $error("tick while stopped");
endmodule
`default_nettype wire

// [rtl/acmpc_spi.sv]
// Four-wire serial slave, oversampled by the core clock; two-byte frames.
// Assumes the host drives SCLK in mode 0 well below a quarter of the core clock.
`timescale 1ns/1ns
`default_nettype none
module acmpc_spi
    import acmpc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic cs_n_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    // Register side
    acmpc_spi_if.port bus
);
    typedef struct packed {
        logic [2:0] sck;
        logic [1:0] mo;
        logic [1:0] cs;
        logic [4:0] bitc;
        logic [7:0] shi;
        logic [7:0] sho;
        logic [6:0] addr;
        logic wnr;
        logic ld;
        logic wr;
        logic rd;
        logic [7:0] wd;
        logic miso;
        logic oe_n;
    } acmpc_spi_s;

    acmpc_spi_s s_q;
    acmpc_spi_s s_d;
    logic rise;
    logic fall;

    always_comb
    begin
        s_d = s_q;
        s_d.wr = 1'b0;
        s_d.rd = 1'b0;
        s_d.ld = 1'b0;
        s_d.sck = {s_q.sck[1:0], sclk_i};
        s_d.mo = {s_q.mo[0], mosi_i};
        s_d.cs = {s_q.cs[0], cs_n_i};
        rise = s_q.sck[1] & ~s_q.sck[2];
        fall = ~s_q.sck[1] & s_q.sck[2];
        if (s_q.cs[1])
        begin
            s_d.bitc = '0;
            s_d.oe_n = 1'b1;
        end
        else
        begin
            s_d.oe_n = 1'b0;
            if (rise)
            begin
                s_d.shi = {s_q.shi[6:0], s_q.mo[1]};
                s_d.bitc = s_q.bitc + 5'h1;
                if (s_q.bitc == CMD_LAST)
                begin
                    s_d.wnr = s_q.shi[6];
                    s_d.addr = {s_q.shi[5:0], s_q.mo[1]};
                    s_d.ld = 1'b1;
                end
                if (s_q.bitc == FRAME_LAST)
                begin
                    s_d.bitc = '0;
                    s_d.wr = s_q.wnr;
                    s_d.wd = {s_q.shi[6:0], s_q.mo[1]};
                end
            end
            if (s_q.ld)
            begin
                s_d.sho = bus.rdata;
                s_d.miso = bus.rdata[7];
                s_d.rd = ~s_q.wnr;
            end
            else if (fall && s_q.bitc > CMD_BITS)
            begin
                s_d.sho = {s_q.sho[6:0], 1'b0};
                s_d.miso = s_q.sho[6];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            s_q <= '{sck: '0, mo: '0, cs: 2'h3, oe_n: 1'b1, default: '0};
        else
            s_q <= s_d;
    end

    assign miso_o = s_q.miso;
    assign miso_oe_n_o = s_q.oe_n;
    assign bus.wr = s_q.wr;
    assign bus.rd = s_q.rd;
    assign bus.addr = s_q.addr;
    assign bus.wdata = s_q.wd;

    a_spi_idle_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_q.cs[1] |=> miso_oe_n_o && s_q.bitc == 5'h0)
        else $error("serial output driven while deselected");
    c_spi_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) s_q.wr);
endmodule
`default_nettype wire

// [verification/acmpc_host.sv]
// SPI host model driving the serial port of the sensor core.
// Assumes mode 0, 16-bit frames and a 64 ns serial clock.
`timescale 1ns/1ns
`default_nettype none
module acmpc_host
(
    // Serial pins
    input wire logic miso_i,
    output logic sclk_o,
    output logic mosi_o,
    output logic cs_n_o
);
    initial
    begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        cs_n_o = 1'b1;
    end
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        #2 cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi_o = tx[i];
            #32 sclk_o = 1'b1;
            if (i < 8)
                rx[i] = miso_i;
            #32 sclk_o = 1'b0;
        end
        #64 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #64;
    endtask
endmodule
`default_nettype wire

// [verification/accel_mode_and_pin_control_bench.sv]
// Bench for the accelerometer mode, sample and pin core.
// Assumes AXI4-Lite access and an SPI host model on the serial pins.
`timescale 1ns/1ns
`default_nettype none
module accel_mode_and_pin_control_bench
    import acmpc_pkg::*;
;
    logic clk, rst_n, ext, awv, wv, bb, arv, rr;
    logic [7:0] awa, ara, rx;
    logic [31:0] wd, d;
    logic [15:0] raw;
    logic [1:0] r, b;
    wire logic awr, wrdy, bv, arr, rv, so, so_n, pa, pa_n, pb, pb_n, awake, sck, si, cs_n;
    wire logic [1:0] rrsp, brsp;
    wire logic [31:0] rdat;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [49:0] t [5] = '{{2'h0, 16'h0123, 32'h123}, {2'h1, 16'h0246, 32'h123},
        {2'h2, 16'hF000, 32'hFFFFFC00}, {2'h0, 16'h7FFF, 32'h7FF}, {2'h0, 16'h0123, 32'h123}};
    acmpc_top #(.BASE_DIV_P(16), .WAKE_DIV_P(200), .EXT_DIV_P(4)) u_dut (
        .CLK_I(clk), .RESETN_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(brsp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bb),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rrsp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
        .SCLK_I(sck), .MOSI_I(si), .CS_N_I(cs_n), .MISO_O(so), .MISO_OE_N_O(so_n),
        .ACCEL_RAW_I(raw), .EVENT_PIN_A_CLOCK_IN_I(pa_n ? ext : pa),
        .EVENT_PIN_A_CLOCK_IN_O(pa), .EVENT_PIN_A_CLOCK_IN_OE_N_O(pa_n),
        .EVENT_PIN_B_SYNC_IN_I(pb_n ? ext : pb), .EVENT_PIN_B_SYNC_IN_O(pb),
        .EVENT_PIN_B_SYNC_IN_OE_N_O(pb_n), .AWAKE_O(awake));
    acmpc_host u_host (.miso_i(so_n ? 1'b1 : so), .sclk_o(sck), .mosi_o(si), .cs_n_o(cs_n));
    task automatic stop_test;
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bb <= 1'b1;
        while (aw || w)
        begin
            @(posedge clk);
            aw = aw && awr !== 1'b1;
            w = w && wrdy !== 1'b1;
            awv <= aw;
            wv <= w;
        end
        while (bv !== 1'b1)
            @(posedge clk);
        b = brsp;
        bb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        @(posedge clk);
        while (arr !== 1'b1)
            @(posedge clk);
        arv <= 1'b0;
        while (rv !== 1'b1)
            @(posedge clk);
        d = rdat;
        r = rrsp;
        rr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    task automatic pulse(input int n);
        repeat (n)
        begin
            ext <= 1'b1;
            repeat (4) @(posedge clk);
            ext <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
        if (++cyc == 10000)
        begin
            n_errors++;
            stop_test();
        end
    initial
    begin
        {rst_n, ext, awv, wv, bb, arv, rr, awa, ara, wd, raw} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (100) @(posedge clk);
        rdc(OFS_CTRL, CTRL_RST);
        rdc(OFS_THR, THR_RST);
        rdc(OFS_STAT, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        chk({31'h0, awake}, 32'h0);
        rdc(8'h10, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h10, 32'hFFFFFFFF);
        chk({30'h0, b}, {30'h0, RESP_SLVERR});
        rdc(OFS_CTRL, CTRL_RST);
        for (int i = 0; i < 5; i++)
        begin
            raw <= t[i][47:32];
            wr(OFS_CTRL, 32'h452 | {28'h0, t[i][49:48], 2'h0});
            chk({30'h0, b}, {30'h0, RESP_OKAY});
            repeat (64) @(posedge clk);
            rdc(OFS_DATA, t[i][31:0]);
        end
        repeat (17) @(posedge clk);
        rd(OFS_STAT);
        chk({31'h0, d[0]}, 32'h1);
        chk({31'h0, pb}, 32'h1);
        wr(OFS_CTRL, 32'h400);
        raw <= 16'h0111;
        repeat (100) @(posedge clk);
        rd(OFS_STAT);
        chk({31'h0, d[0]}, 32'h1);
        rdc(OFS_DATA, 32'h123);
        wr(OFS_STAT, 32'h7);
        raw <= 16'h0400;
        wr(OFS_CTRL, 32'h483);
        repeat (500) @(posedge clk);
        rd(OFS_STAT);
        chk({30'h0, d[2:1]}, 32'h3);
        rd(OFS_CTRL);
        chk({30'h0, d[1:0]}, 32'h2);
        chk({30'h0, pa, awake}, 32'h3);
        wr(OFS_CTRL, 32'h300);
        repeat (2) @(posedge clk);
        chk({30'h0, pa_n, pb_n}, 32'h3);
        u_host.xfer(16'h8C5A, rx);
        @(posedge clk);
        rdc(OFS_THR, 32'h0001015A);
        u_host.xfer(16'h0C00, rx);
        chk({24'h0, rx}, 32'h5A);
        @(posedge clk);
        wr(OFS_STAT, 32'h7);
        raw <= 16'h0055;
        wr(OFS_CTRL, 32'h352);
        repeat (64) @(posedge clk);
        rdc(OFS_STAT, 32'h0);
        pulse(3);
        rdc(OFS_DATA, 32'h55);
        raw <= 16'h0066;
        wr(OFS_CTRL, 32'h152);
        repeat (64) @(posedge clk);
        rdc(OFS_STAT, 32'h0);
        pulse(4);
        rdc(OFS_DATA, 32'h66);
        stop_test();
    end
endmodule
`default_nettype wire
